/* File: logic/fcsg_cfg.svh */
`ifndef FCSG_CFG_SVH
`define FCSG_CFG_SVH
`define FCSG_OP_READ 8'h03
`define FCSG_OP_FREAD 8'h0B
`define FCSG_OP_RDSR 8'h05
`define FCSG_OP_RDFSR 8'h70
`define FCSG_OP_PROG 8'h02
`define FCSG_OP_OTP 8'h42
`define FCSG_OP_SE 8'hD8
`define FCSG_OP_SSE 8'h20
`define FCSG_OP_WRSR 8'h01
`define FCSG_OP_WRNV 8'hB1
`define FCSG_OP_DIE 8'hC4
`define FCSG_OP_WRV 8'h81
`define FCSG_OP_WREV 8'h61
`define FCSG_OP_WREN 8'h06
`define FCSG_OP_WRDI 8'h04
`define FCSG_OP_CLFS 8'h50
`define FCSG_OP_WRLK 8'hE5
`define FCSG_OP_PSUS 8'h75
`define FCSG_OP_ESUS 8'hB0
`define FCSG_OP_CRC 8'h9B
`define FCSG_SUB_CRC 8'h27
`define FCSG_OPT_RANGE 8'hFE
`define FCSG_OP_RDCRC 8'h96
`define FCSG_CRC_POLY 64'h42F0E1EBA9EA3693
`define FCSG_VCFG_XIP_BIT 3
`define FCSG_NV_XIP_OFF 3'h7
`define FCSG_IDX_SUB 5'h01
`define FCSG_IDX_OPT 5'h02
`define FCSG_IDX_EXP 5'h03
`define FCSG_IDX_EXP_END 5'h0A
`define FCSG_IDX_START 5'h0B
`define FCSG_IDX_START_END 5'h0E
`define FCSG_IDX_STOP 5'h0F
`define FCSG_IDX_STOP_END 5'h12
`define FCSG_CRC_LEN 5'h13
`define FCSG_ADDR3_BYTES 3'h3
`define FCSG_ADDR4_BYTES 3'h4
`define FCSG_BYTE_BITS 4'h8
`define FCSG_CMD_EDGES 7'h08
`endif

/* File: logic/fcsg_pkg.sv */
package fcsg_pkg;
	typedef enum logic [1:0] {
		ST_STANDBY = 2'h0,
		ST_BUSY = 2'h1,
		ST_SUSPEND = 2'h3,
		ST_ERASE_SUSP = 2'h2
	} fcsg_state_t;
	typedef enum logic [3:0] {
		CL_NONE, CL_RD_MEM, CL_RD_REG, CL_PROG, CL_ERASE,
		CL_WR_IDLE, CL_WR_ANY, CL_SUSP, CL_CRC
	} fcsg_class_t;
	typedef enum logic [1:0] {
		PH_IDLE = 2'h0,
		PH_CMD = 2'h1,
		PH_BODY = 2'h3
	} fcsg_phase_t;
endpackage : fcsg_pkg

/* File: logic/fcsg_state_gate.sv */
`timescale 1ns/1ps
`include "fcsg_cfg.svh"

// How it works
// R1 - Range CRC opens with activation byte, CRC sub-command, range option byte.
// R2 - Bytes four to eleven carry expected 64-bit CRC, low byte first.
// R3 - Bytes twelve to fifteen carry the start address, low byte first.
// R4 - Bytes sixteen to nineteen carry the stop address, low byte first.
// R5 - CRC starts only on chip select rising after the last byte.
// R6 - One device state at a time; standby accepts all but suspend.
// R7 - Array reads refused during program or erase, accepted otherwise.
// R8 - Reads of the erase-suspended sector are accepted; data may be stale.
// R9 - Status and flag status reads accepted in every state.
// R10 - Array program in standby or erase suspend, never the suspended sector.
// R11 - Sector and subsector erase accepted only in standby.
// R12 - Status, nonvolatile, one-time area and die erase writes only in standby.
// R13 - Volatile, enable, disable, flag clear, lock writes refused only when busy.
// R14 - Suspend commands accepted only while program or erase runs.
// R15 - Execute in place: clear volatile bit 3, then confirm bit zero on fast read.
// R16 - In execute in place each frame starts with address, no command byte.
// R17 - Confirm bit one leaves execute in place and sets volatile bit 3.
// R18 - Nonvolatile field bits 11 to 9 make power-up enter execute in place.
// R19 - Confirm bit is the lowest data line in the first dummy clock.
// R20 - In dual mode the second data line is ignored in that clock.
// R21 - In quad mode lines one to three are ignored in that clock.
// R22 - Computed CRC is compared with expected; result shown as flag bit 4.
// R23 - CRC-64 standard polynomial, data fed low bit first, seed zero.
// R24 - Readback register cleared at CRC start, loaded only on mismatch.
// R25 - Refused commands change no state, operation or register.
// R26 - Range covers start through stop inclusive in ascending order.
module fcsg_state_gate #(
	parameter int SECT_LSB = 16
) (
	// Clock and reset
	input wire logic ref_clk_in,
	input wire logic rst_in,
	// Serial pins from the host
	input wire logic spi_cs_n_in,
	input wire logic spi_sck_in,
	input wire logic [3:0] spi_dq_in,
	// Configuration and device state
	input wire logic [1:0] io_lanes_in,
	input wire logic four_byte_addr_in,
	input wire logic [2:0] nv_xip_mode_in,
	input wire fcsg_pkg::fcsg_state_t dev_state_in,
	input wire logic [31-SECT_LSB:0] susp_sector_in,
	// Command outcome
	output logic op_done_out,
	output logic [7:0] op_code_out,
	output logic op_accept_out,
	output logic [31:0] op_addr_out,
	output logic xip_active_out,
	output logic vcfg_xip_n_out,
	// Array fetch for the CRC
	output logic array_rd_out,
	output logic [31:0] array_addr_out,
	input wire logic [7:0] array_data_in,
	input wire logic array_valid_in,
	// CRC result
	output logic crc_busy_out,
	output logic crc_fail_out,
	output logic [63:0] crc_readback_out
);
	import fcsg_pkg::*;

	logic cs_m_q, cs_s_q, cs_p_q, sck_m_q, sck_s_q, sck_p_q;
	logic [3:0] dq_m_q, dq_s_q;
	logic sck_rise, cs_rise, byte_end, commit, ok, crc_go, fr_ok, same_sect;
	logic [1:0] lsh;
	logic [3:0] step, bit_cnt_q;
	logic [4:0] byte_idx_q, abase, aend;
	logic [2:0] abytes;
	logic [6:0] edge_cnt_q, conf_edge;
	logic [7:0] sh_q, sh_nx, opcode_q, vdat_q;
	logic [31:0] addr_q, start_q, stop_q, array_addr_q;
	logic [63:0] exp_q, crc_q, crc_nx, crc_readback_q;
	logic pre_q, range_q, conf_q, conf_seen_q, init_q, xip_active_q, vcfg_xip_n_q;
	logic op_done_q, op_accept_q, crc_busy_q, crc_fail_q;
	logic [7:0] op_code_q;
	logic [31:0] op_addr_q;
	fcsg_phase_t phase_q;
	fcsg_class_t cls;

	function automatic fcsg_class_t op_class(input logic [7:0] op);
		fcsg_class_t c;
		c = CL_NONE;
		case (op)
			`FCSG_OP_READ, `FCSG_OP_FREAD: c = CL_RD_MEM;
			`FCSG_OP_RDSR, `FCSG_OP_RDFSR, `FCSG_OP_RDCRC: c = CL_RD_REG;
			`FCSG_OP_PROG: c = CL_PROG;
			`FCSG_OP_SE, `FCSG_OP_SSE: c = CL_ERASE;
			`FCSG_OP_WRSR, `FCSG_OP_WRNV, `FCSG_OP_OTP, `FCSG_OP_DIE: c = CL_WR_IDLE;
			`FCSG_OP_WRV, `FCSG_OP_WREV, `FCSG_OP_WREN: c = CL_WR_ANY;
			`FCSG_OP_WRDI, `FCSG_OP_CLFS, `FCSG_OP_WRLK: c = CL_WR_ANY;
			`FCSG_OP_PSUS, `FCSG_OP_ESUS: c = CL_SUSP;
			`FCSG_OP_CRC: c = CL_CRC;
			default: c = CL_NONE;
		endcase
		return c;
	endfunction : op_class

	function automatic logic op_allowed(input fcsg_state_t st, input fcsg_class_t c,
		input logic same);
		logic g;
		g = 1'b0;
		case (c)
			CL_RD_MEM: g = st != ST_BUSY; // R7 R8
			CL_RD_REG: g = 1'b1; // R9
			CL_PROG: g = st == ST_STANDBY || (st == ST_ERASE_SUSP && !same); // R10
			CL_ERASE: g = st == ST_STANDBY; // R11
			CL_WR_IDLE, CL_CRC: g = st == ST_STANDBY; // R12
			CL_WR_ANY: g = st != ST_BUSY; // R13
			CL_SUSP: g = st == ST_BUSY; // R6 R14
			default: g = 1'b0;
		endcase
		return g;
	endfunction : op_allowed

	// Bits fed low first into a left-shifting register
	function automatic logic [63:0] crc_byte(input logic [63:0] c, input logic [7:0] d);
		logic [63:0] r;
		r = c;
		for (int i = 0; i < 8; i++)
		begin
			r = {r[62:0], 1'b0} ^ ((r[63] ^ d[i]) ? `FCSG_CRC_POLY : 64'h0); // R23
		end
		return r;
	endfunction : crc_byte

	// Pins cross into the clock domain through two flops each
	always_ff @(posedge ref_clk_in)
	begin
		if (rst_in)
		begin
			{cs_m_q, cs_s_q, cs_p_q} <= 3'h7;
			{sck_m_q, sck_s_q, sck_p_q} <= 3'h0;
			dq_m_q <= 4'h0;
			dq_s_q <= 4'h0;
		end
		else
		begin
			{cs_m_q, cs_s_q, cs_p_q} <= {spi_cs_n_in, cs_m_q, cs_s_q};
			{sck_m_q, sck_s_q, sck_p_q} <= {spi_sck_in, sck_m_q, sck_s_q};
			dq_m_q <= spi_dq_in;
			dq_s_q <= dq_m_q;
		end
	end

	assign sck_rise = sck_s_q & ~sck_p_q & ~cs_s_q;
	assign cs_rise = cs_s_q & ~cs_p_q;
	// Lane code 3 is treated as quad
	assign lsh = io_lanes_in[1] ? 2'h2 : {1'b0, io_lanes_in[0]};
	assign step = 4'h1 << lsh;
	assign byte_end = sck_rise && (bit_cnt_q + step) == `FCSG_BYTE_BITS;
	assign abytes = four_byte_addr_in ? `FCSG_ADDR4_BYTES : `FCSG_ADDR3_BYTES;
	assign abase = {4'h0, ~xip_active_q};
	assign aend = abase + {2'h0, abytes};
	assign conf_edge = (xip_active_q ? 7'h00 : (`FCSG_CMD_EDGES >> lsh))
		+ ({1'b0, abytes, 3'h0} >> lsh);

	always_comb
	begin
		case (lsh)
			2'h0: sh_nx = {sh_q[6:0], dq_s_q[0]};
			2'h1: sh_nx = {sh_q[5:0], dq_s_q[1:0]};
			default: sh_nx = {sh_q[3:0], dq_s_q};
		endcase
	end

	// Frame phase and counters; cleared whenever the chip is deselected
	always_ff @(posedge ref_clk_in)
	begin
		if (rst_in || cs_s_q)
		begin
			phase_q <= PH_IDLE;
			bit_cnt_q <= 4'h0;
			byte_idx_q <= 5'h00;
			edge_cnt_q <= 7'h00;
		end
		else if (sck_rise)
		begin
			edge_cnt_q <= (&edge_cnt_q) ? edge_cnt_q : edge_cnt_q + 7'h01;
			bit_cnt_q <= byte_end ? 4'h0 : bit_cnt_q + step;
			if (byte_end && !(&byte_idx_q))
				byte_idx_q <= byte_idx_q + 5'h01;
			unique case (phase_q)
				PH_IDLE: phase_q <= xip_active_q ? PH_BODY : PH_CMD; // R16
				PH_CMD: phase_q <= byte_end ? PH_BODY : PH_CMD;
				PH_BODY: phase_q <= PH_BODY;
				default: phase_q <= PH_IDLE;
			endcase
		end
	end

	// Byte capture
	always_ff @(posedge ref_clk_in)
	begin
		if (rst_in)
		begin
			sh_q <= 8'h00;
			opcode_q <= 8'h00;
			vdat_q <= 8'h00;
			addr_q <= 32'h0;
			exp_q <= 64'h0;
			start_q <= 32'h0;
			stop_q <= 32'h0;
			{pre_q, range_q, conf_q, conf_seen_q} <= 4'h0;
		end
		else if (cs_s_q)
		begin
			// Execute in place implies a fast read with no opcode
			opcode_q <= xip_active_q ? `FCSG_OP_FREAD : 8'h00; // R16
			addr_q <= 32'h0;
			{pre_q, range_q, conf_seen_q} <= 3'h0;
		end
		else if (sck_rise)
		begin
			sh_q <= sh_nx;
			// Only the lowest line counts; the others are don't care
			if (edge_cnt_q == conf_edge && opcode_q == `FCSG_OP_FREAD)
			begin
				conf_q <= dq_s_q[0]; // R19 R20 R21
				conf_seen_q <= 1'b1;
			end
			if (byte_end && phase_q == PH_CMD)
				opcode_q <= sh_nx;
			else if (byte_end)
			begin
				if (byte_idx_q >= abase && byte_idx_q < aend)
					addr_q <= {addr_q[23:0], sh_nx};
				if (byte_idx_q == `FCSG_IDX_SUB)
				begin
					pre_q <= sh_nx == `FCSG_SUB_CRC; // R1
					vdat_q <= sh_nx;
				end
				if (byte_idx_q == `FCSG_IDX_OPT)
					range_q <= pre_q && sh_nx == `FCSG_OPT_RANGE; // R1
				if (byte_idx_q >= `FCSG_IDX_EXP && byte_idx_q <= `FCSG_IDX_EXP_END)
					exp_q <= {sh_nx, exp_q[63:8]}; // R2
				if (byte_idx_q >= `FCSG_IDX_START && byte_idx_q <= `FCSG_IDX_START_END)
					start_q <= {sh_nx, start_q[31:8]}; // R3
				if (byte_idx_q >= `FCSG_IDX_STOP && byte_idx_q <= `FCSG_IDX_STOP_END)
					stop_q <= {sh_nx, stop_q[31:8]}; // R4
			end
		end
	end

	// A frame ending mid-byte is void
	assign commit = cs_rise && phase_q != PH_IDLE && bit_cnt_q == 4'h0;
	assign cls = op_class(opcode_q);
	assign same_sect = addr_q[31:SECT_LSB] == susp_sector_in;
	assign ok = op_allowed(dev_state_in, cls, same_sect) && (cls != CL_CRC
		|| (range_q && byte_idx_q == `FCSG_CRC_LEN && start_q <= stop_q && !crc_busy_q));
	assign crc_go = commit && ok && cls == CL_CRC; // R5
	assign fr_ok = commit && ok && opcode_q == `FCSG_OP_FREAD && conf_seen_q;

	// Refused commands only report; nothing else moves
	always_ff @(posedge ref_clk_in)
	begin
		if (rst_in)
		begin
			op_done_q <= 1'b0;
			op_accept_q <= 1'b0;
			op_code_q <= 8'h00;
			op_addr_q <= 32'h0;
		end
		else
		begin
			op_done_q <= commit;
			if (commit)
			begin
				op_accept_q <= ok; // R25
				op_code_q <= opcode_q;
				op_addr_q <= addr_q;
			end
		end
	end

	// Execute-in-place control
	always_ff @(posedge ref_clk_in)
	begin
		if (rst_in)
		begin
			init_q <= 1'b0;
			xip_active_q <= 1'b0;
			vcfg_xip_n_q <= 1'b1;
		end
		else if (!init_q)
		begin
			init_q <= 1'b1;
			xip_active_q <= nv_xip_mode_in != `FCSG_NV_XIP_OFF; // R18
		end
		else if (fr_ok && xip_active_q && conf_q)
		begin
			xip_active_q <= 1'b0; // R17
			vcfg_xip_n_q <= 1'b1;
		end
		else if (fr_ok && !xip_active_q && !vcfg_xip_n_q && !conf_q)
			xip_active_q <= 1'b1; // R15
		else if (commit && ok && opcode_q == `FCSG_OP_WRV && byte_idx_q > `FCSG_IDX_SUB)
			vcfg_xip_n_q <= vdat_q[`FCSG_VCFG_XIP_BIT]; // R13 R15
	end

	// CRC engine: one array byte per accepted fetch
	assign crc_nx = crc_byte(crc_q, array_data_in);
	always_ff @(posedge ref_clk_in)
	begin
		if (rst_in)
		begin
			crc_busy_q <= 1'b0;
			crc_fail_q <= 1'b0;
			crc_q <= 64'h0;
			crc_readback_q <= 64'h0;
			array_addr_q <= 32'h0;
		end
		else if (crc_go)
		begin
			crc_q <= 64'h0; // R23
			crc_readback_q <= 64'h0; // R24
			crc_fail_q <= 1'b0;
			array_addr_q <= start_q;
			crc_busy_q <= 1'b1;
		end
		else if (crc_busy_q && array_valid_in)
		begin
			crc_q <= crc_nx;
			if (array_addr_q == stop_q)
			begin
				crc_busy_q <= 1'b0; // R26
				crc_fail_q <= crc_nx != exp_q; // R22
				if (crc_nx != exp_q)
					crc_readback_q <= crc_nx; // R24
			end
			else
				array_addr_q <= array_addr_q + 32'h1; // R26
		end
	end

	assign op_done_out = op_done_q;
	assign op_code_out = op_code_q;
	assign op_accept_out = op_accept_q;
	assign op_addr_out = op_addr_q;
	assign xip_active_out = xip_active_q;
	assign vcfg_xip_n_out = vcfg_xip_n_q;
	assign array_rd_out = crc_busy_q;
	assign array_addr_out = array_addr_q;
	assign crc_busy_out = crc_busy_q;
	assign crc_fail_out = crc_fail_q;
	assign crc_readback_out = crc_readback_q;

	default clocking cb @(posedge ref_clk_in);
	endclocking
	default disable iff (rst_in);

	sequence s_done(fcsg_class_t c);
		op_done_q && op_class(op_code_q) == c;
	endsequence
	sequence s_crc_end;
		$fell(crc_busy_q) ##0 !crc_fail_q;
	endsequence

	chk_susp_gate: assert property (s_done(CL_SUSP) ##0 op_accept_q // R14
		|-> $past(dev_state_in) == ST_BUSY) else $error("suspend taken outside busy");
	chk_read_busy: assert property (s_done(CL_RD_MEM) // R7
		##0 $past(dev_state_in) == ST_BUSY |-> !op_accept_q) else $error("read taken while busy");
	chk_reg_read: assert property (s_done(CL_RD_REG) |-> op_accept_q) // R9
		else $error("register read refused");
	chk_erase_idle: assert property (s_done(CL_ERASE) ##0 op_accept_q // R11
		|-> $past(dev_state_in) == ST_STANDBY) else $error("erase taken outside standby");
	chk_write_idle: assert property (s_done(CL_WR_IDLE) ##0 op_accept_q // R12
		|-> $past(dev_state_in) == ST_STANDBY) else $error("write taken outside standby");
	chk_write_any: assert property (s_done(CL_WR_ANY) // R13
		##0 $past(dev_state_in) != ST_BUSY |-> op_accept_q) else $error("write refused");
	chk_prog_sector: assert property (s_done(CL_PROG) ##0 $past(dev_state_in) == ST_ERASE_SUSP // R10
		##0 op_addr_q[31:SECT_LSB] == $past(susp_sector_in) |-> !op_accept_q)
		else $error("program of suspended sector taken");
	chk_xip_exit: assert property ($fell(xip_active_q) // R17
		|-> vcfg_xip_n_q && $past(conf_q)) else $error("xip exit wrong");
	chk_xip_enter: assert property ($rose(xip_active_q) && $past(init_q) // R15
		|-> $past(vcfg_xip_n_q) == 1'b0 && $past(conf_q) == 1'b0) else $error("xip entry wrong");
	chk_boot_xip: assert property ($rose(init_q) // R18
		|-> xip_active_q == ($past(nv_xip_mode_in) != `FCSG_NV_XIP_OFF)) else $error("boot xip");
	chk_crc_clear: assert property (crc_go |=> crc_busy_q // R24
		&& crc_readback_q == 64'h0 && !crc_fail_q) else $error("crc start not clean");
	chk_crc_pass: assert property (s_crc_end |-> crc_readback_q == 64'h0) // R22
		else $error("readback loaded on pass");
	chk_crc_walk: assert property (crc_busy_q && array_valid_in && array_addr_q != stop_q // R26
		|=> array_addr_q == $past(array_addr_q) + 32'h1) else $error("crc walk skipped");
endmodule : fcsg_state_gate

/* File: verification/fcsg_host.sv */
`timescale 1ns/1ps
module fcsg_host (
	// Serial pins toward the device
	output logic cs_n_out,
	output logic sck_out,
	output logic [3:0] dq_out
);
	// The serial clock stands still low between frames
	initial
	begin
		cs_n_out = 1'b1;
		sck_out = 1'b0;
		dq_out = 4'h0;
	end
	task automatic xfer(input logic [7:0] b [0:18], input int n, input logic [1:0] ln);
		int w;
		logic [7:0] s;
		logic [3:0] v;
		w = (ln == 2'h0) ? 1 : (ln == 2'h1) ? 2 : 4;
		#20 cs_n_out = 1'b0;
		for (int k = 0; k < n; k++)
		begin
			s = b[k];
			for (int e = 0; e < 8 / w; e++)
			begin
				// Unused lanes flip so a stale level never looks like data
				v = ~dq_out;
				case (w)
					1: v[0] = s[7];
					2: v[1:0] = s[7:6];
					default: v = s[7:4];
				endcase
				dq_out = v;
				s = s << w;
				#32 sck_out = 1'b1;
				#32 sck_out = 1'b0;
			end
		end
		#32 cs_n_out = 1'b1;
		dq_out = ~dq_out;
		#40;
	endtask : xfer
endmodule : fcsg_host

/* File: verification/flash_cmd_state_gate_xip_tb.sv */
`timescale 1ns/1ps
`include "fcsg_cfg.svh"
module flash_cmd_state_gate_xip_tb;
	import fcsg_pkg::*;
	logic clk = 1'b0;
	logic rst = 1'b1;
	logic cs_n, sck, done, acc, xip, vcfg_n, a_rd, busy, fail;
	logic [3:0] dq;
	logic [1:0] lanes = 2'h0;
	logic four_b = 1'b1;
	logic [2:0] nv = 3'h7;
	fcsg_state_t st = ST_STANDBY;
	logic [15:0] susp = 16'h0;
	logic [7:0] a_data = 8'h0;
	logic a_valid = 1'b0;
	logic [7:0] code;
	logic [31:0] addr, a_addr;
	logic [63:0] rdbk;
	logic [31:0] seed = 32'h9158D8B8;
	logic [7:0] fb [0:18];
	int fn = 0;
	logic got = 1'b0;
	int miscompares = 0;
	int n_tests = 0;
	logic [7:0] ops [0:21] = '{`FCSG_OP_PROG, `FCSG_OP_PROG, `FCSG_OP_READ, `FCSG_OP_FREAD,
		`FCSG_OP_RDSR, `FCSG_OP_RDFSR, `FCSG_OP_RDCRC, `FCSG_OP_SE, `FCSG_OP_SSE, `FCSG_OP_WRSR,
		`FCSG_OP_WRNV, `FCSG_OP_OTP, `FCSG_OP_DIE, `FCSG_OP_WRV, `FCSG_OP_WREV, `FCSG_OP_WREN,
		`FCSG_OP_WRDI, `FCSG_OP_CLFS, `FCSG_OP_WRLK, `FCSG_OP_PSUS, `FCSG_OP_ESUS, 8'hA5};

	always #2.5 clk = ~clk;

	fcsg_state_gate u_fcsg_state_gate (.ref_clk_in(clk), .rst_in(rst), .spi_cs_n_in(cs_n),
		.spi_sck_in(sck), .spi_dq_in(dq), .io_lanes_in(lanes), .four_byte_addr_in(four_b),
		.nv_xip_mode_in(nv), .dev_state_in(st), .susp_sector_in(susp), .op_done_out(done),
		.op_code_out(code), .op_accept_out(acc), .op_addr_out(addr), .xip_active_out(xip),
		.vcfg_xip_n_out(vcfg_n), .array_rd_out(a_rd), .array_addr_out(a_addr),
		.array_data_in(a_data), .array_valid_in(a_valid), .crc_busy_out(busy),
		.crc_fail_out(fail), .crc_readback_out(rdbk));
	fcsg_host u_fcsg_host (.cs_n_out(cs_n), .sck_out(sck), .dq_out(dq));

	function automatic logic [31:0] rn();
		seed = {seed[30:0], seed[31] ^ seed[21] ^ seed[1] ^ seed[0]};
		return seed;
	endfunction : rn
	function automatic logic [7:0] mem(input logic [31:0] a);
		return a[7:0] ^ a[15:8] ^ 8'h3C;
	endfunction : mem
	function automatic logic [63:0] crc_of(input logic [31:0] s, input logic [31:0] e);
		logic [63:0] c;
		logic [7:0] d;
		c = 64'h0;
		for (logic [32:0] a = {1'b0, s}; a <= {1'b0, e}; a++)
		begin
			d = mem(a[31:0]);
			for (int i = 0; i < 8; i++)
				c = {c[62:0], 1'b0} ^ ((c[63] ^ d[i]) ? `FCSG_CRC_POLY : 64'h0);
		end
		return c;
	endfunction : crc_of
	function automatic logic exp_acc(input logic [7:0] op, input fcsg_state_t s, input logic same);
		case (op)
			`FCSG_OP_READ, `FCSG_OP_FREAD: return s != ST_BUSY;
			`FCSG_OP_RDSR, `FCSG_OP_RDFSR, `FCSG_OP_RDCRC: return 1'b1;
			`FCSG_OP_PROG: return s == ST_STANDBY || (s == ST_ERASE_SUSP && !same);
			`FCSG_OP_SE, `FCSG_OP_SSE: return s == ST_STANDBY;
			`FCSG_OP_WRSR, `FCSG_OP_WRNV, `FCSG_OP_OTP, `FCSG_OP_DIE: return s == ST_STANDBY;
			`FCSG_OP_PSUS, `FCSG_OP_ESUS: return s == ST_BUSY;
			8'hA5: return 1'b0;
			default: return s != ST_BUSY;
		endcase
	endfunction : exp_acc

	// The commit pulse may land while the host task is still winding down
	always @(posedge clk)
		if (done === 1'b1)
			got = 1'b1;
	always @(negedge clk)
	begin
		a_valid = (a_rd === 1'b1) && rn() > 32'h60000000;
		a_data = mem(a_addr);
	end

	task chk(input logic ok, input string m);
		n_tests++;
		// An unknown result counts as a mismatch
		if (ok !== 1'b1)
		begin
			$display("CHECK FAILED %0t %s", $time, m);
			miscompares++;
		end
	endtask : chk
	task put(input logic [7:0] b);
		fb[fn] = b;
		fn++;
	endtask : put
	task putw(input logic [31:0] w, input int nb, input logic lsb);
		for (int i = 0; i < nb; i++)
			put(lsb ? w[8 * i +: 8] : w[8 * (nb - 1 - i) +: 8]);
	endtask : putw
	task frame(input logic [1:0] ln);
		@(negedge clk);
		lanes = ln;
		got = 1'b0;
		u_fcsg_host.xfer(fb, fn, ln);
		fn = 0;
		for (int i = 0; i < 30 && !got; i++)
			@(negedge clk);
		chk(got === 1'b1, "no commit");
	endtask : frame
	task do_reset(input logic [2:0] m);
		@(negedge clk);
		nv = m;
		rst = 1'b1;
		repeat (10) @(negedge clk);
		rst = 1'b0;
		repeat (4) @(negedge clk);
	endtask : do_reset
	task xip_rd(input logic [1:0] ln, input logic cmd, input logic xb);
		logic [31:0] a;
		logic [7:0] d;
		a = rn();
		d = 8'(rn());
		// Only the lowest lane carries the confirm bit; the rest stay random
		case (ln)
			2'h0: d[7] = xb;
			2'h1: d[6] = xb;
			default: d[4] = xb;
		endcase
		if (cmd)
			put(`FCSG_OP_FREAD);
		putw(a, 4, 1'b0);
		put(d);
		frame(ln);
		chk(xip === ~xb && vcfg_n === xb, "xip state");
		chk(code === `FCSG_OP_FREAD && addr === a, "xip read");
	endtask : xip_rd
	task crc_run(input logic [31:0] s, input logic [31:0] e, input logic bad, input int nb,
		input logic ea);
		logic [63:0] x;
		logic [63:0] pr;
		logic [31:0] r;
		logic pf;
		x = crc_of(s, e);
		pf = fail;
		pr = rdbk;
		r = rn();
		put(`FCSG_OP_CRC);
		put(`FCSG_SUB_CRC);
		put(`FCSG_OPT_RANGE);
		putw(x[31:0] ^ {31'h0, bad}, 4, 1'b1);
		putw(x[63:32], 4, 1'b1);
		putw(s, 4, 1'b1);
		putw(e, 4, 1'b1);
		fn = nb;
		frame(r[1:0]);
		chk(acc === ea, "crc accept");
		for (int i = 0; i < 400 && busy === 1'b1; i++)
			@(negedge clk);
		if (ea)
			chk(busy === 1'b0 && fail === bad && rdbk === (bad ? x : 64'h0), "crc");
		else
			chk(fail === pf && rdbk === pr && busy === 1'b0, "crc refused");
	endtask : crc_run
	task end_sim;
		$display("Checks %0d, mismatches %0d", n_tests, miscompares);
		if (miscompares == 0 && n_tests > 0)
			$display("Finished cleanly");
		else
			$display("Finished with errors");
		$finish;
	endtask : end_sim

	initial
	begin
		#400000;
		miscompares++;
		end_sim;
	end

	initial
	begin
		logic [31:0] a;
		logic [31:0] r;
		logic e;
		logic same;
		logic ad;
		logic vx;
		vx = 1'b1;
		r = rn();
		do_reset(r[2:0] == 3'h7 ? 3'h1 : r[2:0]);
		chk(xip === 1'b1, "boot xip");
		xip_rd(2'h0, 1'b0, 1'b1);
		do_reset(3'h7);
		chk(xip === 1'b0, "no boot xip");
		for (int s = 0; s < 4; s++)
			for (int i = 0; i < 22; i++)
			begin
				r = rn();
				a = rn();
				same = (i == 1) || (i > 1 && r[8]);
				ad = ops[i] inside {`FCSG_OP_PROG, `FCSG_OP_READ, `FCSG_OP_FREAD,
					`FCSG_OP_SE, `FCSG_OP_SSE};
				@(negedge clk);
				st = fcsg_state_t'(s[1:0]);
				four_b = r[4];
				if (!four_b)
					a[31:24] = 8'h0;
				susp = same ? a[31:16] : ~a[31:16];
				put(ops[i]);
				if (ad)
					putw(a, four_b ? 4 : 3, 1'b0);
				if (ops[i] == `FCSG_OP_WRV)
					put(r[23:16]);
				frame(r[1:0]);
				e = exp_acc(ops[i], st, same);
				if (e && ops[i] == `FCSG_OP_WRV)
					vx = r[19];
				chk(acc === e && code === ops[i], "gate");
				chk(vcfg_n === vx && xip === 1'b0, "side effect");
				if (ad)
					chk(addr === a, "address");
			end
		@(negedge clk);
		st = ST_STANDBY;
		four_b = 1'b1;
		for (int ln = 0; ln < 3; ln++)
		begin
			r = rn();
			put(`FCSG_OP_WRV);
			put(r[7:0] & 8'hF7);
			frame(ln[1:0]);
			chk(vcfg_n === 1'b0, "vcfg clear");
			xip_rd(ln[1:0], 1'b1, 1'b0);
			xip_rd(ln[1:0], 1'b0, 1'b0);
			xip_rd(ln[1:0], 1'b0, 1'b1);
		end
		a = rn() & 32'h7FFFFFF0;
		r = rn();
		crc_run(a, a + {28'h0, r[3:0]}, 1'b0, 19, 1'b1);
		crc_run(a, a + 32'hB, 1'b1, 19, 1'b1);
		crc_run(a + 32'h5, a + 32'h5, 1'b1, 19, 1'b1);
		crc_run(a + 32'h1, a, 1'b0, 19, 1'b0);
		crc_run(a, a + 32'h3, 1'b0, 18, 1'b0);
		@(negedge clk);
		st = ST_BUSY;
		crc_run(a, a + 32'h3, 1'b0, 19, 1'b0);
		end_sim;
	end
endmodule : flash_cmd_state_gate_xip_tb
